// ### design/dao_ctrl.sv
// Output, power-mode and serial command logic of the dual converter
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Sample each channel on its clock rise
// - Shutdown low, enable low: run and drive
// - Shutdown low, enable high: convert, bus off
// - Shutdown high, enable low: nap, bus off
// - Shutdown high, enable high: sleep, bus off
// - Amplifier powerdown high powers amplifier down
// - Mode level picks format and stabilizer
// - One mode setting serves both channels
// - Swap select high: A on A, B on B
// - Swap select low: buses exchanged
// - Select low: shift data on serial clock
// - Select rising: stop shifting, execute command
// - Accept 24 or 32 bit commands
// - Overrange high on either channel overflow
module dao_ctrl (
    // Clock and reset
    input  wire logic                          core_clk_in,
    input  wire logic                          rst_in,
    // Channel pins
    input  wire logic                          chan_a_sample_clock_in,
    input  wire logic                          chan_b_sample_clock_in,
    input  wire logic                          chan_a_converter_shutdown_in,
    input  wire logic                          chan_b_converter_shutdown_in,
    input  wire logic                          chan_a_output_enable_n_in,
    input  wire logic                          chan_b_output_enable_n_in,
    input  wire logic                          chan_a_amplifier_powerdown_in,
    input  wire logic                          chan_b_amplifier_powerdown_in,
    input  wire logic [1:0]                    mode_level_in,
    input  wire logic                          output_bus_swap_select_in,
    // Converter core results
    input  wire logic [dao_pkg::SAMPLE_W-1:0]  chan_a_result_in,
    input  wire logic [dao_pkg::SAMPLE_W-1:0]  chan_b_result_in,
    input  wire logic                          chan_a_overflow_in,
    input  wire logic                          chan_b_overflow_in,
    // Serial command port
    input  wire logic                          serial_select_load_in,
    input  wire logic                          serial_clock_in,
    input  wire logic                          serial_data_in,
    // Output buses
    output logic [dao_pkg::SAMPLE_W-1:0]       output_bus_a_out,
    output logic                               output_bus_a_oe_n_out,
    output logic [dao_pkg::SAMPLE_W-1:0]       output_bus_b_out,
    output logic                               output_bus_b_oe_n_out,
    output logic                               data_ready_clock_out,
    output logic                               overrange_flag_out,
    // Power and mode status
    output logic [3:0]                         chan_a_power_state_out,
    output logic [3:0]                         chan_b_power_state_out,
    output logic                               chan_a_amp_enable_out,
    output logic                               chan_b_amp_enable_out,
    output logic                               twos_complement_out,
    output logic                               stabilizer_on_out,
    // Auxiliary gain command
    output logic [dao_pkg::CMD_W-1:0]          dac_command_out,
    output logic                               dac_command_long_out,
    output logic                               dac_command_valid_out,
    output logic                               dac_command_error_out
);

    // ==================================================================
    // Pin synchroniser: three stages, a change counts once stages agree
    logic [dao_pkg::PIN_W-1:0] pin_raw;
    logic [dao_pkg::PIN_W-1:0] pin_s1;
    logic [dao_pkg::PIN_W-1:0] pin_s2;
    logic [dao_pkg::PIN_W-1:0] pin_s3;
    logic [dao_pkg::PIN_W-1:0] pin_agree;
    logic [dao_pkg::PIN_W-1:0] pin;
    logic [dao_pkg::PIN_W-1:0] pin_prev;
    logic [dao_pkg::PIN_W-1:0] pin_rise;

    assign pin_raw[dao_pkg::PIN_CLK_A]  = chan_a_sample_clock_in;
    assign pin_raw[dao_pkg::PIN_CLK_B]  = chan_b_sample_clock_in;
    assign pin_raw[dao_pkg::PIN_SHDN_A] = chan_a_converter_shutdown_in;
    assign pin_raw[dao_pkg::PIN_SHDN_B] = chan_b_converter_shutdown_in;
    assign pin_raw[dao_pkg::PIN_OEN_A]  = chan_a_output_enable_n_in;
    assign pin_raw[dao_pkg::PIN_OEN_B]  = chan_b_output_enable_n_in;
    assign pin_raw[dao_pkg::PIN_AMP_A]  = chan_a_amplifier_powerdown_in;
    assign pin_raw[dao_pkg::PIN_AMP_B]  = chan_b_amplifier_powerdown_in;
    assign pin_raw[dao_pkg::PIN_MODE0]  = mode_level_in[0];
    assign pin_raw[dao_pkg::PIN_MODE1]  = mode_level_in[1];
    assign pin_raw[dao_pkg::PIN_SWAP]   = output_bus_swap_select_in;
    assign pin_raw[dao_pkg::PIN_SSEL]   = serial_select_load_in;
    assign pin_raw[dao_pkg::PIN_SCLK]   = serial_clock_in;
    assign pin_raw[dao_pkg::PIN_SDATA]  = serial_data_in;

    assign pin_agree = ~(pin_s2 ^ pin_s3);
    assign pin_rise  = pin & ~pin_prev;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pin_s1   <= dao_pkg::PIN_RESET;
            pin_s2   <= dao_pkg::PIN_RESET;
            pin_s3   <= dao_pkg::PIN_RESET;
            pin      <= dao_pkg::PIN_RESET;
            pin_prev <= dao_pkg::PIN_RESET;
        end else begin
            pin_s1   <= pin_raw;
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin      <= (pin_agree & pin_s3) | (~pin_agree & pin);
            pin_prev <= pin;
        end
    end

    // ==================================================================
    // Power modes and the shared format/stabilizer mode
    dao_pkg::dao_power_type pwr_a;
    dao_pkg::dao_power_type pwr_b;
    logic                   conv_a;
    logic                   conv_b;
    logic [1:0]             mode;

    assign mode   = {pin[dao_pkg::PIN_MODE1], pin[dao_pkg::PIN_MODE0]};
    // Nap and sleep both stop conversion; hi-z keeps converting
    assign conv_a = (pwr_a == dao_pkg::PWR_NORMAL) ||
                    (pwr_a == dao_pkg::PWR_HIZ);
    assign conv_b = (pwr_b == dao_pkg::PWR_NORMAL) ||
                    (pwr_b == dao_pkg::PWR_HIZ);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pwr_a <= dao_pkg::PWR_NORMAL;
            pwr_b <= dao_pkg::PWR_NORMAL;
        end else begin
            pwr_a <= dao_pkg::dao_power_decode(pin[dao_pkg::PIN_SHDN_A],
                                               pin[dao_pkg::PIN_OEN_A]);
            pwr_b <= dao_pkg::dao_power_decode(pin[dao_pkg::PIN_SHDN_B],
                                               pin[dao_pkg::PIN_OEN_B]);
        end
    end

    assign chan_a_power_state_out = pwr_a;
    assign chan_b_power_state_out = pwr_b;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            chan_a_amp_enable_out <= 1'b0;
            chan_b_amp_enable_out <= 1'b0;
            twos_complement_out   <= 1'b0;
            stabilizer_on_out     <= 1'b0;
        end else begin
            chan_a_amp_enable_out <= ~pin[dao_pkg::PIN_AMP_A];
            chan_b_amp_enable_out <= ~pin[dao_pkg::PIN_AMP_B];
            // One setting for both channels, no per-channel copy
            twos_complement_out   <= mode[1];
            stabilizer_on_out     <= (mode == dao_pkg::MODE_THIRD) ||
                                     (mode == dao_pkg::MODE_TWO3);
        end
    end

    // ==================================================================
    // Sample capture on each channel's clock rise
    logic [dao_pkg::SAMPLE_W-1:0] raw_a;
    logic [dao_pkg::SAMPLE_W-1:0] raw_b;
    logic                         ovf_a;
    logic                         ovf_b;
    logic                         take_a;
    logic                         take_b;

    assign take_a = pin_rise[dao_pkg::PIN_CLK_A] && conv_a;
    assign take_b = pin_rise[dao_pkg::PIN_CLK_B] && conv_b;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            raw_a <= dao_pkg::SAMPLE_RESET;
            ovf_a <= 1'b0;
        end else if (take_a) begin
            raw_a <= chan_a_result_in;
            ovf_a <= chan_a_overflow_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            raw_b <= dao_pkg::SAMPLE_RESET;
            ovf_b <= 1'b0;
        end else if (take_b) begin
            raw_b <= chan_b_result_in;
            ovf_b <= chan_b_overflow_in;
        end
    end

    // ==================================================================
    // Output multiplexer; one select sample steers both buses at once
    // so no word can carry bits of both channels
    logic [dao_pkg::SAMPLE_W-1:0] fmt_a;
    logic [dao_pkg::SAMPLE_W-1:0] fmt_b;
    logic                         drive_a;
    logic                         drive_b;
    logic                         swap_sel;

    assign fmt_a    = dao_pkg::dao_format(raw_a, twos_complement_out);
    assign fmt_b    = dao_pkg::dao_format(raw_b, twos_complement_out);
    assign drive_a  = (pwr_a == dao_pkg::PWR_NORMAL);
    assign drive_b  = (pwr_b == dao_pkg::PWR_NORMAL);
    assign swap_sel = pin[dao_pkg::PIN_SWAP];

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            output_bus_a_out      <= dao_pkg::SAMPLE_RESET;
            output_bus_b_out      <= dao_pkg::SAMPLE_RESET;
            output_bus_a_oe_n_out <= 1'b1;
            output_bus_b_oe_n_out <= 1'b1;
        end else if (swap_sel) begin
            output_bus_a_out      <= fmt_a;
            output_bus_b_out      <= fmt_b;
            output_bus_a_oe_n_out <= ~drive_a;
            output_bus_b_oe_n_out <= ~drive_b;
        end else begin
            output_bus_a_out      <= fmt_b;
            output_bus_b_out      <= fmt_a;
            output_bus_a_oe_n_out <= ~drive_b;
            output_bus_b_oe_n_out <= ~drive_a;
        end
    end

    // Ready clock follows channel B; data settles before its fall
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            data_ready_clock_out <= 1'b0;
            overrange_flag_out   <= 1'b0;
        end else begin
            data_ready_clock_out <= pin_prev[dao_pkg::PIN_CLK_B];
            overrange_flag_out   <= ovf_a | ovf_b;
        end
    end

    // ==================================================================
    // Serial command shifter
    dao_pkg::dao_serial_type   ser_state;
    logic [dao_pkg::CMD_W-1:0] shreg;
    logic [dao_pkg::CNT_W-1:0] bit_cnt;
    logic                      sel_low;
    logic                      sel_rise;
    logic                      sclk_rise;

    assign sel_low   = ~pin[dao_pkg::PIN_SSEL];
    assign sel_rise  = pin_rise[dao_pkg::PIN_SSEL];
    assign sclk_rise = pin_rise[dao_pkg::PIN_SCLK];

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ser_state <= dao_pkg::SER_IDLE;
            shreg     <= dao_pkg::CMD_RESET;
            bit_cnt   <= dao_pkg::CNT_RESET;
        end else begin
            case (ser_state)
                dao_pkg::SER_IDLE: begin
                    if (sel_low) begin
                        ser_state <= dao_pkg::SER_SHIFT;
                        bit_cnt   <= dao_pkg::CNT_RESET;
                    end
                end
                dao_pkg::SER_SHIFT: begin
                    if (sel_rise) begin
                        ser_state <= dao_pkg::SER_IDLE;
                    end else if (sel_low && sclk_rise) begin
                        shreg <= {shreg[dao_pkg::CMD_W-2:0],
                                  pin[dao_pkg::PIN_SDATA]};
                        if (bit_cnt != dao_pkg::CNT_MAX) begin
                            bit_cnt <= bit_cnt + 6'h01;
                        end
                    end
                end
                default: ser_state <= dao_pkg::SER_IDLE;
            endcase
        end
    end

    // Only exact 24 or 32 bit frames execute; others raise an error pulse
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            dac_command_out       <= dao_pkg::CMD_RESET;
            dac_command_long_out  <= 1'b0;
            dac_command_valid_out <= 1'b0;
            dac_command_error_out <= 1'b0;
        end else begin
            dac_command_valid_out <= 1'b0;
            dac_command_error_out <= 1'b0;
            if (ser_state == dao_pkg::SER_SHIFT && sel_rise) begin
                if (bit_cnt == dao_pkg::CMD_LONG_LEN) begin
                    dac_command_out       <= shreg;
                    dac_command_long_out  <= 1'b1;
                    dac_command_valid_out <= 1'b1;
                end else if (bit_cnt == dao_pkg::CMD_SHORT_LEN) begin
                    dac_command_out       <= {8'h00, shreg[23:0]};
                    dac_command_long_out  <= 1'b0;
                    dac_command_valid_out <= 1'b1;
                end else begin
                    dac_command_error_out <= 1'b1;
                end
            end
        end
    end

    // ==================================================================
    // Checks
    default clocking dao_cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    chk_sample_take_a: assert property (take_a |=>
        raw_a == $past(chan_a_result_in)) else $error("sample A missed");
    chk_normal_drive: assert property (swap_sel && drive_a |=>
        !output_bus_a_oe_n_out) else $error("bus A not driven");
    chk_hiz_convert: assert property (pwr_b == dao_pkg::PWR_HIZ &&
        pin_rise[dao_pkg::PIN_CLK_B] |=> raw_b == $past(chan_b_result_in)
        && ($past(swap_sel) ? output_bus_b_oe_n_out :
        output_bus_a_oe_n_out)) else $error("hi-z wrong");
    chk_nap_decode: assert property (pin[dao_pkg::PIN_SHDN_A] &&
        !pin[dao_pkg::PIN_OEN_A] |=> pwr_a == dao_pkg::PWR_NAP ##1
        (output_bus_a_oe_n_out || !$past(swap_sel))) else $error("nap wrong");
    chk_sleep_hold: assert property (pwr_a == dao_pkg::PWR_SLEEP &&
        pin_rise[dao_pkg::PIN_CLK_A] |=> $stable(raw_a))
        else $error("sleep still samples");
    chk_amp_power: assert property ($rose(pin[dao_pkg::PIN_AMP_B]) |=>
        !chan_b_amp_enable_out) else $error("amp B not down");
    chk_mode_decode: assert property (mode == dao_pkg::MODE_SUPPLY |=>
        twos_complement_out && !stabilizer_on_out) else $error("mode");
    chk_bus_straight: assert property (swap_sel |=>
        output_bus_a_out == $past(fmt_a) && output_bus_b_out == $past(fmt_b))
        else $error("straight mux wrong");
    chk_bus_swapped: assert property (!swap_sel |=>
        output_bus_a_out == $past(fmt_b) && output_bus_b_out == $past(fmt_a))
        else $error("swapped mux wrong");
    chk_serial_shift: assert property (ser_state == dao_pkg::SER_SHIFT &&
        sel_low && sclk_rise |=> shreg[0] == $past(pin[dao_pkg::PIN_SDATA])
        && shreg[31:1] == $past(shreg[30:0])) else $error("shift wrong");
    chk_short_cmd: assert property (ser_state == dao_pkg::SER_SHIFT &&
        sel_rise && bit_cnt == dao_pkg::CMD_SHORT_LEN |=>
        dac_command_valid_out ##1 !dac_command_valid_out)
        else $error("24-bit command lost");
    chk_overrange: assert property (take_b && chan_b_overflow_in |->
        ##2 overrange_flag_out) else $error("overrange missing");

    cov_long_cmd: cover property (dac_command_valid_out &&
        dac_command_long_out);
    cov_short_cmd: cover property (dac_command_valid_out &&
        !dac_command_long_out);
    cov_swap_change: cover property ($fell(swap_sel) ##[1:40] take_a);
    cov_nap_entry: cover property (pwr_a == dao_pkg::PWR_NAP);

endmodule : dao_ctrl

`default_nettype wire

// ### pkg/dao_pkg.sv
// Shared constants, types and decode functions for the dual converter control
package dao_pkg;

    // ==================================================================
    // Widths
    localparam int SAMPLE_W = 14;
    localparam int CMD_W    = 32;
    localparam int CNT_W    = 6;
    localparam int PIN_W    = 14;

    // ==================================================================
    // Serial command lengths and bit counter limit
    localparam logic [CNT_W-1:0] CMD_SHORT_LEN = 6'h18;
    localparam logic [CNT_W-1:0] CMD_LONG_LEN  = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX       = 6'h21;

    // ==================================================================
    // Positions of the pin inputs inside the synchroniser vector
    localparam int PIN_CLK_A  = 0;
    localparam int PIN_CLK_B  = 1;
    localparam int PIN_SHDN_A = 2;
    localparam int PIN_SHDN_B = 3;
    localparam int PIN_OEN_A  = 4;
    localparam int PIN_OEN_B  = 5;
    localparam int PIN_AMP_A  = 6;
    localparam int PIN_AMP_B  = 7;
    localparam int PIN_MODE0  = 8;
    localparam int PIN_MODE1  = 9;
    localparam int PIN_SWAP   = 10;
    localparam int PIN_SSEL   = 11;
    localparam int PIN_SCLK   = 12;
    localparam int PIN_SDATA  = 13;

    // ==================================================================
    // Values after reset
    // Serial select idles high; resetting it low would fake a select rise
    // and an error pulse straight after reset
    localparam logic [PIN_W-1:0]    PIN_RESET    = 14'h0800;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 14'h0000;
    localparam logic [CMD_W-1:0]    CMD_RESET    = 32'h0000_0000;
    localparam logic [CNT_W-1:0]    CNT_RESET    = 6'h00;

    // ==================================================================
    // Four-level mode input, coded ground, third, two thirds, supply
    localparam logic [1:0] MODE_GND    = 2'h0;
    localparam logic [1:0] MODE_THIRD  = 2'h1;
    localparam logic [1:0] MODE_TWO3   = 2'h2;
    localparam logic [1:0] MODE_SUPPLY = 2'h3;

    // ==================================================================
    // State types
    typedef enum logic [3:0] {
        PWR_NORMAL = 4'h1,
        PWR_HIZ    = 4'h2,
        PWR_NAP    = 4'h4,
        PWR_SLEEP  = 4'h8
    } dao_power_type;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'h1,
        SER_SHIFT = 2'h2
    } dao_serial_type;

    // ==================================================================
    // Decode functions
    function automatic dao_power_type dao_power_decode(input logic shdn,
                                                       input logic oen);
        dao_power_type r;
        r = PWR_NORMAL;
        case ({shdn, oen})
            2'h0:    r = PWR_NORMAL;
            2'h1:    r = PWR_HIZ;
            2'h2:    r = PWR_NAP;
            2'h3:    r = PWR_SLEEP;
            default: r = PWR_NORMAL;
        endcase
        return r;
    endfunction : dao_power_decode

    // Raw words are straight binary; two's complement flips the MSB
    function automatic logic [SAMPLE_W-1:0] dao_format(
        input logic [SAMPLE_W-1:0] w,
        input logic                twos);
        return twos ? {~w[SAMPLE_W-1], w[SAMPLE_W-2:0]} : w;
    endfunction : dao_format

endpackage : dao_pkg

// ### bench/dao_host.sv
// Host model: drives sample clocks and serial port, captures output buses
`timescale 1ns/1ps
`default_nettype none
module dao_host (
    // Clock
    input  wire logic                         core_clk_in,
    // Device outputs
    input  wire logic                         data_ready_clock_in,
    input  wire logic [dao_pkg::SAMPLE_W-1:0] bus_a_in,
    input  wire logic                         bus_a_oe_n_in,
    input  wire logic [dao_pkg::SAMPLE_W-1:0] bus_b_in,
    input  wire logic                         bus_b_oe_n_in,
    // Host drives
    output logic                              chan_a_sample_clock_out,
    output logic                              chan_b_sample_clock_out,
    output logic                              serial_select_load_out,
    output logic                              serial_clock_out,
    output logic                              serial_data_out
);
    logic                         smp_clk;
    logic [dao_pkg::SAMPLE_W-1:0] cap_a;
    logic [dao_pkg::SAMPLE_W-1:0] cap_b;

    // ==================================================================
    // Both channels run from one shared clock
    assign chan_a_sample_clock_out = smp_clk;
    assign chan_b_sample_clock_out = smp_clk;

    initial begin
        smp_clk = 1'b0;
        serial_select_load_out = 1'b1;
        serial_clock_out = 1'b0;
        serial_data_out = 1'b1;
        cap_a = '0;
        cap_b = '0;
    end

    // ==================================================================
    // A released bus reads as the inverse of what it last carried
    always @(negedge data_ready_clock_in) begin
        cap_a <= bus_a_oe_n_in ? ~cap_a : bus_a_in;
        cap_b <= bus_b_oe_n_in ? ~cap_b : bus_b_in;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : wait_cyc

    // One 80 ns sample clock period, rising edge first
    task automatic sample();
        smp_clk = 1'b1;
        wait_cyc(10);
        smp_clk = 1'b0;
        wait_cyc(10);
    endtask : sample

    // Serial clock idles low outside frames; data changes while it is low
    task automatic send(input logic [31:0] word, input int n);
        serial_select_load_out = 1'b0;
        wait_cyc(10);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_out = word[i];
            wait_cyc(10);
            serial_clock_out = 1'b1;
            wait_cyc(10);
            serial_clock_out = 1'b0;
        end
        wait_cyc(10);
        serial_select_load_out = 1'b1;
        serial_data_out = ~serial_data_out;
        wait_cyc(20);
    endtask : send
endmodule : dao_host
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the dual converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk, rst, shdn_a, shdn_b, oen_a, oen_b, amp_a, amp_b;
    logic        swap, ovf_a, ovf_b, tw;
    logic [1:0]  mode;
    logic [13:0] res_a, res_b, exp_a, exp_b, fa, fb;
    wire  logic  sclk_a, sclk_b, ssel, sck, sdi, oe_a, oe_b, drdy, ovr;
    wire  logic  ampen_a, ampen_b, twos, stab, cmd_long, cmd_valid, cmd_err;
    wire  logic [13:0] bus_a, bus_b;
    wire  logic [3:0]  pwr_a, pwr_b;
    wire  logic [31:0] cmd;
    int          num_errors = 0;
    int          checks = 0;
    int          valid_cnt = 0;
    int          err_cnt = 0;
    int          cycles = 0;

    dao_ctrl dut (.core_clk_in(core_clk), .rst_in(rst),
        .chan_a_sample_clock_in(sclk_a), .chan_b_sample_clock_in(sclk_b),
        .chan_a_converter_shutdown_in(shdn_a),
        .chan_b_converter_shutdown_in(shdn_b),
        .chan_a_output_enable_n_in(oen_a), .chan_b_output_enable_n_in(oen_b),
        .chan_a_amplifier_powerdown_in(amp_a),
        .chan_b_amplifier_powerdown_in(amp_b),
        .mode_level_in(mode), .output_bus_swap_select_in(swap),
        .chan_a_result_in(res_a), .chan_b_result_in(res_b),
        .chan_a_overflow_in(ovf_a), .chan_b_overflow_in(ovf_b),
        .serial_select_load_in(ssel), .serial_clock_in(sck),
        .serial_data_in(sdi), .output_bus_a_out(bus_a),
        .output_bus_a_oe_n_out(oe_a), .output_bus_b_out(bus_b),
        .output_bus_b_oe_n_out(oe_b), .data_ready_clock_out(drdy),
        .overrange_flag_out(ovr), .chan_a_power_state_out(pwr_a),
        .chan_b_power_state_out(pwr_b), .chan_a_amp_enable_out(ampen_a),
        .chan_b_amp_enable_out(ampen_b), .twos_complement_out(twos),
        .stabilizer_on_out(stab), .dac_command_out(cmd),
        .dac_command_long_out(cmd_long), .dac_command_valid_out(cmd_valid),
        .dac_command_error_out(cmd_err));

    dao_host host (.core_clk_in(core_clk), .data_ready_clock_in(drdy),
        .bus_a_in(bus_a), .bus_a_oe_n_in(oe_a), .bus_b_in(bus_b),
        .bus_b_oe_n_in(oe_b), .chan_a_sample_clock_out(sclk_a),
        .chan_b_sample_clock_out(sclk_b), .serial_select_load_out(ssel),
        .serial_clock_out(sck), .serial_data_out(sdi));

    // ==================================================================
    // Clock, pulse counting and hang limit
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cmd_valid === 1'b1) valid_cnt++;
        if (cmd_err === 1'b1) err_cnt++;
        if (cycles == 6000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("Checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // ==================================================================
    // Main sequence
    initial begin
        {rst, shdn_a, shdn_b, oen_a, oen_b, amp_a, amp_b} = 7'h40;
        {swap, ovf_a, ovf_b, mode} = 5'h10;
        res_a = '0;
        res_b = '0;
        exp_a = '0;
        exp_b = '0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        host.wait_cyc(8);
        // Opposite power modes on the two channels; only normal and hi-z ones capture
        for (int i = 0; i < 4; i++) begin
            {shdn_a, oen_a} = 2'(i);
            {shdn_b, oen_b} = 2'(3 - i);
            res_a = 14'h0100 + 14'(i);
            res_b = 14'h0200 + 14'(i);
            host.wait_cyc(8);
            host.sample();
            if (i < 2) exp_a = res_a;
            if (i > 1) exp_b = res_b;
            check("pwr_a", pwr_a, 32'(4'h1 << i));
            check("pwr_b", pwr_b, 32'(4'h8 >> i));
            check("oe_a", oe_a, i != 0);
            check("oe_b", oe_b, i != 3);
            check("bus_a", bus_a, exp_a);
            check("bus_b", bus_b, exp_b);
        end
        {shdn_a, oen_a, shdn_b, oen_b} = 4'h0;
        for (int j = 0; j < 2; j++) begin
            amp_a = j[0];
            amp_b = !j[0];
            host.wait_cyc(8);
            check("amp_a", ampen_a, j == 0);
            check("amp_b", ampen_b, j == 1);
        end
        // Every mode level, alternating straight and swapped buses
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            swap = m[0];
            ovf_a = (m == 1);
            ovf_b = (m == 2);
            res_a = 14'h2a5c + 14'(m);
            res_b = 14'h1337 - 14'(m);
            host.wait_cyc(8);
            host.sample();
            tw = m > 1;
            fa = {res_a[13] ^ tw, res_a[12:0]};
            fb = {res_b[13] ^ tw, res_b[12:0]};
            check("twos", twos, tw);
            check("stab", stab, m == 1 || m == 2);
            check("bus_a", bus_a, swap ? fa : fb);
            check("bus_b", bus_b, swap ? fb : fa);
            check("host_a", host.cap_a, swap ? fa : fb);
            check("host_b", host.cap_b, swap ? fb : fa);
            check("ovr", ovr, m == 1 || m == 2);
        end
        // Swap alone moves both buses at once
        swap = 1'b0;
        host.wait_cyc(8);
        check("swap_a", bus_a, fb);
        check("swap_b", bus_b, fa);
        // Short frame, long frame, then one bit too many
        host.send(32'hffab_cdef, 24);
        check("cmd24", cmd, 32'h00ab_cdef);
        check("long24", cmd_long, 1'b0);
        check("valid24", valid_cnt, 1);
        host.send(32'hdead_beef, 32);
        check("cmd32", cmd, 32'hdead_beef);
        check("long32", cmd_long, 1'b1);
        check("valid32", valid_cnt, 2);
        host.send(32'h0155_aa55, 25);
        check("cmd25", cmd, 32'hdead_beef);
        check("err25", err_cnt, 1);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
